// ===== core/clii_consts.vh
/*
  Constants for the character display instruction interface:
  instruction field positions, reset values and timing counts.
  Assumes a 200 MHz core clock; execution times are scaled from a 320 kHz
  display clock.
*/
`ifndef CLII_CONSTS_VH
`define CLII_CONSTS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLII_CLK_HZ          200000000
`define CLII_T_CLEAR_NS      1280000
`define CLII_T_SHORT_NS      31000
`define CLII_T_POWERON_NS    10000000
`define CLII_T_ADD_NS        4700
`define CLII_CYC_CLEAR       ((`CLII_T_CLEAR_NS / 5))
`define CLII_CYC_SHORT       ((`CLII_T_SHORT_NS / 5))
`define CLII_CYC_POWERON     ((`CLII_T_POWERON_NS / 5))
`define CLII_CYC_ADD         ((`CLII_T_ADD_NS + 4) / 5)

// ----------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------
`define CLII_BIT_CLEAR       0
`define CLII_BIT_HOME        1
`define CLII_BIT_ENTRY       2
`define CLII_BIT_ONOFF       3
`define CLII_BIT_SHIFT       4
`define CLII_BIT_FUNC        5
`define CLII_BIT_GLYPH       6
`define CLII_BIT_DDADR       7

// ----------------------------------------------------------------
// Reset values and geometry
// ----------------------------------------------------------------
`define CLII_SPACE_CHAR      8'h20
`define CLII_DD_DEPTH        80
`define CLII_ROW_BITS        80
`define CLII_CHAR_COLS       5
`define CLII_RST_ENTRY       2'h2
`define CLII_RST_FUNC        3'h4
`define CLII_RST_BUSWIDTH    1'b1
`endif

// ===== core/clii_row_shifter.v
/*
  Row bitmap shifter: accepts one pixel per cycle, shifts it toward the
  serial output and keeps the last 80 bits as the segment latch.
  Assumes the caller presents pixels in the order it wants them emitted.
*/
`timescale 1ns/1ps
`include "clii_consts.vh"

module clii_row_shifter
(
  input  wire                     i_ref_clk,
  input  wire                     i_sys_rst,
  input  wire                     i_pix_valid,
  input  wire                     i_pix,
  input  wire                     i_row_latch,
  output reg                      o_serial,
  output reg  [`CLII_ROW_BITS-1:0] o_segments
);

  reg [`CLII_ROW_BITS-1:0] shreg;

  // ----------------------------------------------------------------
  // Shift chain and latch
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      shreg      <= {`CLII_ROW_BITS{1'b0}};
      o_serial   <= 1'b0;
      o_segments <= {`CLII_ROW_BITS{1'b0}};
    end
    else
    begin
      if (i_pix_valid)
      begin
        // Oldest bit falls out to cascaded drivers
        o_serial <= shreg[`CLII_ROW_BITS-1];
        shreg    <= {shreg[`CLII_ROW_BITS-2:0], i_pix};
      end
      if (i_row_latch)
        o_segments <= shreg;  // Last 80 bits shown
    end
  end

endmodule

// ===== core/clii_top.v
/*
  Instruction interface of a dot-matrix character display controller.
  Host writes/reads instruction and data registers over a 4/8-bit bus;
  the block decodes, times execution, reports busy, moves the address
  counter and streams row bitmaps to a shifter.
  Assumes host strobes are synchronous single-cycle pulses on i_ref_clk.
*/
`timescale 1ns/1ps
`include "clii_consts.vh"

module clii_top
#(
  parameter [31:0] POWERON_CYC = `CLII_CYC_POWERON,
  parameter [31:0] CLEAR_CYC   = `CLII_CYC_CLEAR
)
(
  input  wire                      i_ref_clk,
  input  wire                      i_sys_rst,
  input  wire                      i_wr_stb,
  input  wire                      i_rd_stb,
  input  wire                      i_register_select,
  input  wire [7:0]                i_host_data_lines,
  input  wire                      i_row_shift_direction_select,
  output reg  [7:0]                o_host_data_lines,
  output reg                       o_host_data_oe_n,
  output reg                       o_busy_flag_bit,
  output reg  [6:0]                o_addr_counter,
  output reg                       o_bus_width_select,
  output reg                       o_two_lines,
  output reg                       o_font_tall,
  output reg                       o_display_on,
  output reg                       o_cursor_on,
  output reg                       o_blink_on,
  output reg  [6:0]                o_cursor_pos,
  output reg  [6:0]                o_display_offset,
  output reg                       o_glyph_sel,
  output wire                      o_serial,
  output wire [`CLII_ROW_BITS-1:0] o_segments
);

  localparam ST_IDLE = 2'h0;
  localparam ST_EXEC = 2'h1;
  localparam ST_ADD  = 2'h2;

  reg  [1:0]  state;
  reg  [31:0] cnt;
  reg  [7:0]  cmd;
  reg         cmd_data;
  reg         poweron;
  reg         nib_phase;
  reg  [3:0]  hi_nib;
  reg  [7:0]  rd_byte;
  reg         inc_mode;
  reg         shift_mode;
  reg  [7:0]  display_data_ram [0:`CLII_DD_DEPTH-1];
  reg  [7:0]  glyph_ram [0:63];
  reg  [6:0]  clr_idx;
  reg         clearing;
  reg  [2:0]  pix_idx;
  reg         row_latch;
  reg         pix_valid;
  wire [7:0]  status_byte;
  wire [4:0]  pix_src;
  wire        full_byte;
  wire [7:0]  in_byte;

  assign status_byte = {o_busy_flag_bit, o_addr_counter};
  assign full_byte   = o_bus_width_select | nib_phase;
  assign in_byte     = o_bus_width_select ? i_host_data_lines
                                          : {hi_nib, i_host_data_lines[7:4]};
  assign pix_src     = glyph_ram[{o_addr_counter[2:0], 3'h0}][4:0];

  // ----------------------------------------------------------------
  // Host port, decode and execution timing
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state              <= ST_EXEC;
      cnt                <= 32'h0;
      cmd                <= 8'h00;
      cmd_data           <= 1'b0;
      poweron            <= 1'b1;
      nib_phase          <= 1'b0;
      hi_nib             <= 4'h0;
      rd_byte            <= 8'h00;
      o_host_data_lines  <= 8'h00;
      o_host_data_oe_n   <= 1'b1;
      o_busy_flag_bit    <= 1'b1;
      o_addr_counter     <= 7'h00;
      o_bus_width_select <= `CLII_RST_BUSWIDTH;
      o_two_lines        <= 1'b0;
      o_font_tall        <= 1'b0;
      o_display_on       <= 1'b0;
      o_cursor_on        <= 1'b0;
      o_blink_on         <= 1'b0;
      o_cursor_pos       <= 7'h00;
      o_display_offset   <= 7'h00;
      o_glyph_sel        <= 1'b0;
      inc_mode           <= 1'b1;
      shift_mode         <= 1'b0;
      clearing           <= 1'b1;
      clr_idx            <= 7'h00;
    end
    else
    begin
      o_host_data_oe_n <= ~i_rd_stb;
      o_cursor_pos     <= o_addr_counter;
      // Reads: status always allowed, nibble order high then low
      if (i_rd_stb)
      begin
        if (!o_bus_width_select && nib_phase)
          o_host_data_lines <= {rd_byte[3:0], 4'h0};
        else if (!i_register_select)
        begin
          rd_byte           <= status_byte;
          o_host_data_lines <= status_byte;
        end
        else
        begin
          rd_byte           <= o_glyph_sel ? glyph_ram[o_addr_counter[5:0]]
                                           : display_data_ram[o_addr_counter];
          o_host_data_lines <= o_glyph_sel ? glyph_ram[o_addr_counter[5:0]]
                                           : display_data_ram[o_addr_counter];
        end
        if (!o_bus_width_select)
          nib_phase <= ~nib_phase;
      end
      else if (i_wr_stb && !full_byte)
      begin
        hi_nib    <= i_host_data_lines[7:4];
        nib_phase <= 1'b1;
      end
      else if (i_wr_stb)
        nib_phase <= 1'b0;
      // Clear fill runs over display RAM during execution
      if (clearing)
      begin
        display_data_ram[clr_idx] <= `CLII_SPACE_CHAR;
        clr_idx         <= (clr_idx == 7'h4f) ? 7'h00 : clr_idx + 7'h01;
        clearing        <= (clr_idx != 7'h4f);
      end
      case (state)
        ST_IDLE:
        begin
          // Accept one full byte; anything else while busy never reaches here
          if ((i_wr_stb && full_byte) || (i_rd_stb && i_register_select && full_byte))
          begin
            cmd             <= in_byte;
            cmd_data        <= i_register_select;
            o_busy_flag_bit <= 1'b1;
            state           <= ST_EXEC;
            cnt             <= `CLII_CYC_SHORT;
            if (i_wr_stb && i_register_select)
            begin
              if (o_glyph_sel)
                glyph_ram[o_addr_counter[5:0]] <= in_byte;
              else
                display_data_ram[o_addr_counter]      <= in_byte;
              if (shift_mode && !o_glyph_sel)
                o_display_offset <= inc_mode ? o_display_offset + 7'h01
                                             : o_display_offset - 7'h01;
            end
            else if (!i_register_select)
            begin
              if (in_byte[`CLII_BIT_DDADR])
              begin
                o_addr_counter <= in_byte[6:0];
                o_glyph_sel    <= 1'b0;
              end
              else if (in_byte[`CLII_BIT_GLYPH])
              begin
                o_addr_counter <= {1'b0, in_byte[5:0]};
                o_glyph_sel    <= 1'b1;
              end
              else if (in_byte[`CLII_BIT_FUNC])
              begin
                o_bus_width_select <= in_byte[4];
                o_two_lines        <= in_byte[3];
                o_font_tall        <= in_byte[2];
              end
              else if (in_byte[`CLII_BIT_SHIFT])
              begin
                if (in_byte[3])
                  o_display_offset <= in_byte[2] ? o_display_offset + 7'h01
                                                 : o_display_offset - 7'h01;
                else
                  o_addr_counter <= in_byte[2] ? o_addr_counter + 7'h01
                                               : o_addr_counter - 7'h01;
              end
              else if (in_byte[`CLII_BIT_ONOFF])
              begin
                o_display_on <= in_byte[2];
                o_cursor_on  <= in_byte[1];
                o_blink_on   <= in_byte[0];
              end
              else if (in_byte[`CLII_BIT_ENTRY])
              begin
                inc_mode   <= in_byte[1];
                shift_mode <= in_byte[0];
              end
              else if (in_byte[`CLII_BIT_HOME])
              begin
                o_addr_counter   <= 7'h00;
                o_display_offset <= 7'h00;
                o_glyph_sel      <= 1'b0;
                cnt              <= CLEAR_CYC;
              end
              else if (in_byte[`CLII_BIT_CLEAR])
              begin
                o_addr_counter   <= 7'h00;
                o_display_offset <= 7'h00;
                o_glyph_sel      <= 1'b0;
                inc_mode         <= 1'b1;
                clearing         <= 1'b1;
                clr_idx          <= 7'h00;
                cnt              <= CLEAR_CYC;
              end
            end
          end
        end
        ST_EXEC:
        begin
          // Reads are still answered here; no write or read starts an instruction
          // Power-on wait runs once, after the reset-time fill
          if (cnt == 32'h0 && !clearing && poweron)
          begin
            poweron <= 1'b0;
            cnt     <= POWERON_CYC;
          end
          else if (cnt == 32'h0 && !clearing)
          begin
            o_busy_flag_bit <= 1'b0;
            cmd             <= 8'hff;
            state           <= cmd_data ? ST_ADD : ST_IDLE;
            cnt             <= cmd_data ? `CLII_CYC_ADD : 32'h0;
          end
          else if (cnt != 32'h0)
            cnt <= cnt - 32'h1;
        end
        ST_ADD:
        begin
          // Counter steps after busy drops
          if (cnt == 32'h0)
          begin
            o_addr_counter <= inc_mode ? o_addr_counter + 7'h01
                                       : o_addr_counter - 7'h01;
            state          <= ST_IDLE;
          end
          else
            cnt <= cnt - 32'h1;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Row pixel sequencer
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pix_idx   <= 3'h0;
      pix_valid <= 1'b0;
      row_latch <= 1'b0;
    end
    else
    begin
      pix_valid <= 1'b1;
      pix_idx   <= (pix_idx == 3'h4) ? 3'h0 : pix_idx + 3'h1;
      row_latch <= (pix_idx == 3'h4);
    end
  end

  clii_row_shifter u_shift
  (
    .i_ref_clk   (i_ref_clk),
    .i_sys_rst   (i_sys_rst),
    .i_pix_valid (pix_valid),
    .i_pix       (i_row_shift_direction_select ? pix_src[pix_idx]
                                               : pix_src[3'h4 - pix_idx]),
    .i_row_latch (row_latch),
    .o_serial    (o_serial),
    .o_segments  (o_segments)
  );

endmodule

// ===== tb/clii_top_chk.sv
/*
  Checker for the instruction interface: timing relations at its ports.
  Assumes a bind onto clii_top with both count parameters handed on.
*/
`timescale 1ns/1ps
module clii_top_chk
#(
  parameter [31:0] POWERON_CYC = 20,
  parameter [31:0] CLEAR_CYC   = 100
)
(
  input wire       i_ref_clk,
  input wire       i_sys_rst,
  input wire       i_wr_stb,
  input wire       i_rd_stb,
  input wire       i_register_select,
  input wire [7:0] o_host_data_lines,
  input wire       o_host_data_oe_n,
  input wire       o_busy_flag_bit,
  input wire [6:0] o_addr_counter,
  input wire       o_bus_width_select,
  input wire       o_display_on,
  input wire [6:0] o_cursor_pos
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  reg [15:0] run;
  // Length of the current busy stretch
  always @(posedge i_ref_clk or posedge i_sys_rst)
    if (i_sys_rst)
      run <= 16'h0000;
    else
      run <= o_busy_flag_bit ? run + 16'h0001 : 16'h0000;
  rd_drive_a:
    assert property (i_rd_stb |=> !o_host_data_oe_n) else $error("bus idle after read");
  rd_release_a:
    assert property (!i_rd_stb |=> o_host_data_oe_n) else $error("bus driven unasked");
  status_word_a:
    assert property (i_rd_stb && !i_register_select && o_bus_width_select |=>
      o_host_data_lines == {$past(o_busy_flag_bit), $past(o_addr_counter)})
      else $error("status word wrong");
  busy_take_a:
    assert property (i_wr_stb && !o_busy_flag_bit && o_bus_width_select |=> o_busy_flag_bit)
      else $error("busy not raised");
  busy_len_a:
    assert property ($fell(o_busy_flag_bit) |-> $past(run) >= CLEAR_CYC / 2)
      else $error("busy too short");
  poweron_busy_a:
    assert property ($fell(i_sys_rst) |-> o_busy_flag_bit [*8]) else $error("busy early");
  step_late_a:
    assert property (i_wr_stb && i_register_select && !o_busy_flag_bit && o_bus_width_select
      |=> $stable(o_addr_counter) [*8]) else $error("counter stepped early");
  cursor_track_a:
    assert property (o_cursor_pos == $past(o_addr_counter)) else $error("cursor off");
  cfg_quiet_a:
    assert property ($changed(o_display_on) |-> o_busy_flag_bit || $past(o_busy_flag_bit))
      else $error("display bit changed idle");
  cover property (i_rd_stb && !i_register_select && o_busy_flag_bit);
  cover property (i_wr_stb && i_register_select && !o_busy_flag_bit);
  cover property ($fell(o_busy_flag_bit));
endmodule
bind clii_top clii_top_chk #(.POWERON_CYC(POWERON_CYC), .CLEAR_CYC(CLEAR_CYC)) clii_top_chk_inst
(
  .i_ref_clk          (i_ref_clk),
  .i_sys_rst          (i_sys_rst),
  .i_wr_stb           (i_wr_stb),
  .i_rd_stb           (i_rd_stb),
  .i_register_select  (i_register_select),
  .o_host_data_lines  (o_host_data_lines),
  .o_host_data_oe_n   (o_host_data_oe_n),
  .o_busy_flag_bit    (o_busy_flag_bit),
  .o_addr_counter     (o_addr_counter),
  .o_bus_width_select (o_bus_width_select),
  .o_display_on       (o_display_on),
  .o_cursor_pos       (o_cursor_pos)
);

// ===== tb/clii_host_model.sv
/*
  Host model: microcontroller side of the parallel bus.
  Assumes its tasks are called from one process of the bench.
*/
`timescale 1ns/1ps
module clii_host_model
(
  input  wire       i_ref_clk,
  input  wire [7:0] i_rd_data,
  output reg        o_wr_stb,
  output reg        o_rd_stb,
  output reg        o_register_select,
  output reg  [7:0] o_data
);
  // Idle bus at time zero
  initial
  begin
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_register_select = 1'b0;
    o_data = 8'h00;
  end
  // One strobe cycle; released lines show no stale value
  task strobe(input logic rd, input logic rs, input logic [7:0] d);
    begin
      @(posedge i_ref_clk);
      o_register_select <= rs;
      o_data <= d;
      o_wr_stb <= !rd;
      o_rd_stb <= rd;
      @(posedge i_ref_clk);
      o_wr_stb <= 1'b0;
      o_rd_stb <= 1'b0;
      o_data <= ~d;
    end
  endtask
  // Byte write, two upper-line nibbles in four-bit mode
  task wr(input logic rs, input logic [7:0] d, input logic four);
    begin
      if (four)
      begin
        strobe(1'b0, rs, {d[7:4], ~d[3:0]});
        strobe(1'b0, rs, {d[3:0], d[3:0]});
      end
      else
        strobe(1'b0, rs, d);
    end
  endtask
  // Byte read in eight-bit mode
  task rd(input logic rs, output logic [7:0] d);
    begin
      strobe(1'b1, rs, 8'h00);
      #1 d = i_rd_data;
    end
  endtask
endmodule

// ===== tb/clii_top_bench.sv
/*
  Bench for the instruction interface: host model drives, bench checks.
  Assumes the host model and checker are compiled alongside.
*/
`timescale 1ns/1ps
`include "clii_consts.vh"
module clii_top_bench;
  reg                      i_ref_clk;
  reg                      i_sys_rst;
  reg                      i_row_shift_direction_select;
  wire                     wr;
  wire                     rd;
  wire                     rs;
  wire [7:0]               din;
  wire [7:0]               o_host_data_lines;
  wire                     o_busy_flag_bit;
  wire [6:0]               o_addr_counter;
  wire                     bw;
  wire                     two;
  wire                     font;
  wire                     don;
  wire                     con;
  wire                     bon;
  wire [6:0]               o_cursor_pos;
  wire [6:0]               offset;
  wire                     glyph;
  wire [`CLII_ROW_BITS-1:0] segs;
  integer                  failures;
  integer                  comparisons;
  integer                  n;
  reg [7:0]                rv;
  reg [6:0]                ad;
  reg [6:0]                b;
  reg [`CLII_ROW_BITS-1:0] ser;
  wire                     o_serial;
  clii_host_model clii_host_model_inst (.i_ref_clk(i_ref_clk), .i_rd_data(o_host_data_lines),
    .o_wr_stb(wr), .o_rd_stb(rd), .o_register_select(rs), .o_data(din));
  clii_top #(.POWERON_CYC(20), .CLEAR_CYC(100)) clii_top_inst (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_wr_stb(wr), .i_rd_stb(rd), .i_register_select(rs),
    .i_host_data_lines(din), .i_row_shift_direction_select(i_row_shift_direction_select),
    .o_host_data_lines(o_host_data_lines), .o_host_data_oe_n(), .o_busy_flag_bit(o_busy_flag_bit),
    .o_addr_counter(o_addr_counter), .o_bus_width_select(bw), .o_two_lines(two),
    .o_font_tall(font), .o_display_on(don), .o_cursor_on(con), .o_blink_on(bon),
    .o_cursor_pos(o_cursor_pos), .o_display_offset(offset), .o_glyph_sel(glyph),
    .o_serial(o_serial), .o_segments(segs));
  // Comparison and tally
  task chk(input [8*8:1] what, input logic [7:0] seen, input logic [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // Verdict and end of run
  task results;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Bounded wait for busy low
  task idle;
    begin
      n = 0;
      #1;
      while (o_busy_flag_bit !== 1'b0 && n < 7000)
      begin
        @(posedge i_ref_clk);
        #1 n = n + 1;
      end
      if (n >= 7000)
      begin
        failures = failures + 1;
        results;
      end
    end
  endtask
  // Instruction write, then wait out its execution
  task ins(input logic [7:0] d, input logic four);
    begin
      clii_host_model_inst.wr(1'b0, d, four);
      idle;
    end
  endtask
  // Data write; counter must step a fixed delay after busy drops
  task data_step(input logic [6:0] exp);
    begin
      b = o_addr_counter;
      rv = $urandom;
      clii_host_model_inst.wr(1'b1, rv, 1'b0);
      idle;
      chk("early", {1'b0, o_addr_counter}, {1'b0, b});
      n = 0;
      while (o_addr_counter === b && n < 1200)
      begin
        @(posedge i_ref_clk);
        #1 n = n + 1;
      end
      chk("delay", {7'h00, n > 930 && n < 950}, 8'h01);
      chk("counter", {1'b0, o_addr_counter}, {1'b0, exp});
    end
  endtask
  // Row image for one glyph row and a pixel order
  function [`CLII_ROW_BITS-1:0] row_exp(input [4:0] p, input dir);
    integer j;
    begin
      for (j = 0; j < `CLII_ROW_BITS; j = j + 1)
        row_exp[j] = dir ? p[4 - j % 5] : p[j % 5];
    end
  endfunction
  // Serial output gathered over one row length
  always @(posedge i_ref_clk)
    ser <= {ser[`CLII_ROW_BITS-2:0], o_serial};
  // Clock
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Main sequence
  initial
  begin
    failures = 0;
    comparisons = 0;
    i_sys_rst = 1'b1;
    i_row_shift_direction_select = 1'b0;
    rv = $urandom(9);
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1 chk("pwr busy", {7'h00, o_busy_flag_bit}, 8'h01);
    idle;
    clii_host_model_inst.rd(1'b0, rv);
    chk("status", rv, 8'h00);
    $display("test power-on done");
    ins(8'h01, 1'b0);
    chk("clear", {1'b0, o_addr_counter}, 8'h00);
    ins(8'h30, 1'b0);
    chk("func", {5'h00, bw, two, font}, 8'h04);
    ins(8'h08, 1'b0);
    chk("onoff", {5'h00, don, con, bon}, 8'h00);
    clii_host_model_inst.wr(1'b0, 8'h06, 1'b0);
    clii_host_model_inst.wr(1'b0, 8'h0f, 1'b0);
    clii_host_model_inst.rd(1'b0, rv);
    chk("busy rd", {7'h00, rv[7]}, 8'h01);
    idle;
    chk("refused", {5'h00, don, con, bon}, 8'h00);
    $display("test start-up done");
    ad = 7'h01 + $urandom % 78;
    rv = $urandom;
    @(posedge i_ref_clk);
    i_row_shift_direction_select <= rv[0];
    ins({1'b1, ad}, 1'b0);
    chk("dd addr", {glyph, o_addr_counter}, {1'b0, ad});
    data_step(ad + 7'h01);
    ins(8'h04, 1'b0);
    data_step(ad);
    ins(8'h07, 1'b0);
    b = offset;
    data_step(ad + 7'h01);
    chk("shifted", {7'h00, offset !== b}, 8'h01);
    ins(8'h02, 1'b0);
    chk("home", {1'b0, o_addr_counter | offset}, 8'h00);
    $display("test data access done");
    ins(8'h20, 1'b0);
    chk("narrow", {7'h00, bw}, 8'h00);
    rv = 8'h08 | ($urandom & 8'h07);
    ins(rv, 1'b1);
    chk("nibbles", {5'h00, don, con, bon}, {5'h00, rv[2:0]});
    ad = $urandom & 7'h3f;
    ins({2'b01, ad[5:0]}, 1'b1);
    chk("glyph", {glyph, o_addr_counter}, {1'b1, ad});
    @(posedge i_ref_clk);
    #1 chk("cursor", {1'b0, o_cursor_pos}, {1'b0, ad});
    $display("test four-bit done");
    // Glyph row 8 written in nibbles, then shown in both pixel orders
    rv = $urandom;
    ins(8'h48, 1'b1);
    clii_host_model_inst.wr(1'b1, rv, 1'b1);
    idle;
    repeat (1000) @(posedge i_ref_clk);
    chk("glyph st", {1'b0, o_addr_counter}, 8'h09);
    repeat (2)
    begin
      i_row_shift_direction_select <= ~i_row_shift_direction_select;
      repeat (200) @(posedge i_ref_clk);
      n = 0;
      repeat (5)
      begin
        @(posedge i_ref_clk);
        #1 n = n + (segs === ser);
      end
      b = {6'h00, segs === row_exp(rv[4:0], i_row_shift_direction_select)};
      chk("row", {1'b0, b}, 8'h01);
      chk("serial", {7'h00, n != 0}, 8'h01);
      @(posedge i_ref_clk);
    end
    $display("test row done");
    results;
  end
endmodule
